// *** design/pll_serial_pkg.sv ***
// shared constants and types for the synthesizer control port and its host
package pll_serial_pkg;

    // ****************************************
    // frame layout
    // ****************************************
    localparam int          ADDR_BITS       = 6;
    localparam int          DATA_BITS       = 24;
    localparam int          FRAME_RISES     = 32;
    localparam logic [5:0]  LAST_ADDR_RISE  = 6'h06;
    localparam logic [5:0]  FIRST_DATA_RISE = 6'h07;
    localparam logic [5:0]  LAST_DATA_RISE  = 6'h1E;
    localparam logic [5:0]  FINAL_RISE      = 6'h20;

    // ****************************************
    // device register map
    // ****************************************
    localparam logic [5:0]  ADDR_STROBE     = 6'h00;
    localparam logic [5:0]  ADDR_ENABLE     = 6'h01;
    localparam logic [5:0]  ADDR_OVERRIDE   = 6'h02;
    localparam logic [15:0] ENABLE_RESET    = 16'hFE9B;
    localparam logic [1:0]  OVERRIDE_RESET  = 2'h3;

    // strobe register bits
    localparam int          STB_REGS        = 0;
    localparam int          STB_DIGITAL     = 1;
    localparam int          STB_TEMP        = 3;

    // enable register bits
    localparam int          EN_VCO_BUF      = 0;
    localparam int          EN_BIAS         = 1;
    localparam int          EN_REF_DIV      = 2;
    localparam int          EN_REFMUX_DIG   = 3;
    localparam int          EN_DIVREF_DIG   = 4;
    localparam int          EN_SQR_DIG      = 5;
    localparam int          EN_SIN_DIG      = 6;
    localparam int          EN_SQR_BUF      = 7;
    localparam int          EN_SIN_BUF      = 8;
    localparam int          EN_VCO_CLK      = 9;
    localparam int          EN_PRESCALER    = 10;
    localparam int          EN_LOCK_GATE    = 11;
    localparam int          EN_PUMP         = 12;
    localparam int          EN_MODULATOR    = 13;
    localparam int          EN_LOCK_CIRCUIT = 14;
    localparam int          EN_SLIP_GUARD   = 15;

    // override register bits
    localparam int          OVR_VALUE       = 0;
    localparam int          OVR_FORCE       = 1;

    // ****************************************
    // host register map
    // ****************************************
    localparam logic [3:0]  HOST_COMMAND    = 4'h0;
    localparam logic [3:0]  HOST_WDATA      = 4'h1;
    localparam logic [3:0]  HOST_RDATA      = 4'h2;
    localparam logic [3:0]  HOST_STATUS     = 4'h3;
    localparam int          CMD_READ        = 6;
    localparam int          STAT_BUSY       = 0;
    localparam int          STAT_DONE       = 1;

    // ****************************************
    // timing
    // ****************************************
    localparam int          CLOCK_NS        = 5;
    localparam int          SCLK_HALF_NS    = 80;
    localparam logic [4:0]  HALF_CYCLES     = 5'((SCLK_HALF_NS + CLOCK_NS - 1) / CLOCK_NS);

    typedef enum logic [1:0] {
        HOST_IDLE  = 2'b00,
        HOST_SHIFT = 2'b01,
        HOST_GAP   = 2'b11
    } host_state_t;

endpackage

// *** design/pll_link_if.sv ***
// serial programming link between the host controller and the synthesizer
interface pll_link_if;
    logic sen;
    logic sclk;
    logic sdi;
    logic sdo;
    logic sdo_oe_n;
    logic sdo_line;

    // released line floats high through a pull-up
    assign sdo_line = sdo_oe_n ? 1'b1 : sdo;

    modport device(input sen, input sclk, input sdi, output sdo, output sdo_oe_n);
    modport host(output sen, output sclk, output sdi, input sdo_line);
endinterface

// *** design/pll_enable_strobe_regs.sv ***
// synthesizer end: serial slave, enable register, output override and strobes
module pll_enable_strobe_regs
    import pll_serial_pkg::*;
#(
    parameter logic [23:0] CHIP_ID = 24'h00A5A5  // arbitrary value
) (
    input  wire logic      clock,
    input  wire logic      reset,
    pll_link_if.device     link,
    input  wire logic      lock_detect_raw,
    input  wire logic      ref_sine_select,
    input  wire logic      slip_feature_on,
    input  wire logic      integer_mode,
    output logic           vco_buffer_on,
    output logic           bias_on,
    output logic           ref_divider_run,
    output logic           ref_divider_bypass,
    output logic           refmux_clock_gate,
    output logic           divref_to_digital,
    output logic           square_clock_to_digital,
    output logic           sine_clock_to_digital,
    output logic           square_ref_buffer_on,
    output logic           sine_ref_buffer_on,
    output logic           modulator_clock_from_vco,
    output logic           prescaler_on,
    output logic           lock_detect_run,
    output logic           pump_output_on,
    output logic           modulator_run,
    output logic           lock_circuit_run,
    output logic           cycle_slip_guard,
    output logic           soft_reset_digital,
    output logic           temp_measure_strobe
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic [3:0]  sync3;
    logic [3:0]  pin_level;
    logic [3:0]  pin_prev;
    logic        sen_on;
    logic        sclk_rise;
    logic        sdi_bit;
    logic        lock_seen;

    // three stages, a level moves once stages two and three agree
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sync1     <= 4'h0;
            sync2     <= 4'h0;
            sync3     <= 4'h0;
            pin_level <= 4'h0;
            pin_prev  <= 4'h0;
        end else begin
            sync1 <= {lock_detect_raw, link.sen, link.sclk, link.sdi};
            sync2 <= sync1;
            sync3 <= sync2;
            for (int i = 0; i < 4; i++) begin
                if (sync2[i] == sync3[i]) begin
                    pin_level[i] <= sync3[i];
                end
            end
            pin_prev <= pin_level;
        end
    end

    assign lock_seen = pin_level[3];
    assign sen_on    = pin_level[2];
    assign sclk_rise = pin_level[1] & ~pin_prev[1];
    assign sdi_bit   = pin_level[0];

    // ****************************************
    // registers
    // ****************************************
    logic [15:0] enable_ctrl;
    logic [1:0]  serial_override;
    logic [5:0]  bit_count;
    logic        read_cycle;
    logic [5:0]  addr_shift;
    logic [23:0] data_shift;
    logic        sdo_bit;
    logic        commit;
    logic        regs_restore;
    logic        reading;

    // readback mux for the addressed register
    function automatic logic [23:0] read_value(input logic [5:0] addr);
        case (addr)
            ADDR_STROBE:   read_value = CHIP_ID;
            ADDR_ENABLE:   read_value = {8'h00, enable_ctrl};
            ADDR_OVERRIDE: read_value = {22'h000000, serial_override};
            default:       read_value = 24'h000000;
        endcase
    endfunction

    // ****************************************
    // serial frame
    // ****************************************

    // counts sclk rises inside a frame, shifts address and data
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            bit_count  <= 6'h00;
            read_cycle <= 1'b0;
            addr_shift <= 6'h00;
            data_shift <= 24'h000000;
            sdo_bit    <= 1'b0;
            commit     <= 1'b0;
        end else if (!sen_on) begin
            bit_count  <= 6'h00;
            read_cycle <= 1'b0;
            commit     <= 1'b0;
        end else begin
            commit <= 1'b0;
            if (sclk_rise) begin
                if (bit_count != FINAL_RISE) begin
                    bit_count <= bit_count + 6'h01;
                end
                if (bit_count == 6'h00) begin
                    read_cycle <= sdi_bit;
                end else if (bit_count <= LAST_ADDR_RISE) begin
                    addr_shift <= {addr_shift[4:0], sdi_bit};
                    if (bit_count == LAST_ADDR_RISE && read_cycle) begin
                        data_shift <= read_value({addr_shift[4:0], sdi_bit});
                    end
                end else if (bit_count <= LAST_DATA_RISE) begin
                    if (read_cycle) begin
                        sdo_bit    <= data_shift[23];
                        data_shift <= {data_shift[22:0], 1'b0};
                    end else begin
                        data_shift <= {data_shift[22:0], sdi_bit};
                        commit     <= (bit_count == LAST_DATA_RISE);
                    end
                end
            end
        end
    end

    assign reading = sen_on & read_cycle & (bit_count > FIRST_DATA_RISE);

    // strobes fire for one cycle and hold nothing
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            regs_restore        <= 1'b0;
            soft_reset_digital  <= 1'b0;
            temp_measure_strobe <= 1'b0;
        end else begin
            regs_restore        <= commit && addr_shift == ADDR_STROBE
                                   && data_shift[STB_REGS];
            soft_reset_digital  <= commit && addr_shift == ADDR_STROBE
                                   && data_shift[STB_DIGITAL];
            temp_measure_strobe <= commit && addr_shift == ADDR_STROBE
                                   && data_shift[STB_TEMP];
        end
    end

    // stored registers, restored by the register strobe
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            enable_ctrl     <= ENABLE_RESET;
            serial_override <= OVERRIDE_RESET;
        end else if (regs_restore) begin
            enable_ctrl     <= ENABLE_RESET;
            serial_override <= OVERRIDE_RESET;
        end else if (commit) begin
            if (addr_shift == ADDR_ENABLE) begin
                enable_ctrl <= data_shift[15:0];
            end
            if (addr_shift == ADDR_OVERRIDE) begin
                serial_override <= data_shift[1:0];
            end
        end
    end

    // ****************************************
    // block controls
    // ****************************************

    // every block but the modulator clock select and the divider bypass is held off while bias is cleared
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            vco_buffer_on            <= 1'b0;
            bias_on                  <= 1'b0;
            ref_divider_run          <= 1'b0;
            ref_divider_bypass       <= 1'b1;
            refmux_clock_gate        <= 1'b0;
            divref_to_digital        <= 1'b0;
            square_clock_to_digital  <= 1'b0;
            sine_clock_to_digital    <= 1'b0;
            square_ref_buffer_on     <= 1'b0;
            sine_ref_buffer_on       <= 1'b0;
            modulator_clock_from_vco <= 1'b0;
            prescaler_on             <= 1'b0;
            lock_detect_run          <= 1'b0;
            pump_output_on           <= 1'b0;
            modulator_run            <= 1'b0;
            lock_circuit_run         <= 1'b0;
            cycle_slip_guard         <= 1'b0;
        end else begin
            bias_on                  <= enable_ctrl[EN_BIAS];
            vco_buffer_on            <= enable_ctrl[EN_BIAS] & enable_ctrl[EN_VCO_BUF];
            ref_divider_run          <= enable_ctrl[EN_BIAS] & enable_ctrl[EN_REF_DIV];
            ref_divider_bypass       <= ~enable_ctrl[EN_REF_DIV];
            refmux_clock_gate        <= enable_ctrl[EN_BIAS] & enable_ctrl[EN_REFMUX_DIG];
            divref_to_digital        <= enable_ctrl[EN_BIAS] & enable_ctrl[EN_DIVREF_DIG];
            square_clock_to_digital  <= enable_ctrl[EN_BIAS] & enable_ctrl[EN_SQR_DIG];
            sine_clock_to_digital    <= enable_ctrl[EN_BIAS] & enable_ctrl[EN_SIN_DIG];
            square_ref_buffer_on     <= enable_ctrl[EN_BIAS] & enable_ctrl[EN_SQR_BUF]
                                        & ~ref_sine_select;
            sine_ref_buffer_on       <= enable_ctrl[EN_BIAS] & enable_ctrl[EN_SIN_BUF]
                                        & ref_sine_select;
            modulator_clock_from_vco <= enable_ctrl[EN_VCO_CLK];
            prescaler_on             <= enable_ctrl[EN_BIAS] & enable_ctrl[EN_PRESCALER];
            lock_detect_run          <= enable_ctrl[EN_BIAS] & enable_ctrl[EN_LOCK_GATE];
            pump_output_on           <= enable_ctrl[EN_BIAS] & enable_ctrl[EN_PUMP];
            modulator_run            <= enable_ctrl[EN_BIAS] & enable_ctrl[EN_MODULATOR]
                                        & ~integer_mode;
            lock_circuit_run         <= enable_ctrl[EN_BIAS] & enable_ctrl[EN_LOCK_CIRCUIT];
            cycle_slip_guard         <= enable_ctrl[EN_BIAS] & enable_ctrl[EN_SLIP_GUARD]
                                        & slip_feature_on;
        end
    end

    // ****************************************
    // shared serial out / lock detect pin
    // ****************************************

    // force wins, then read data, then gated lock detect
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            link.sdo      <= 1'b0;
            link.sdo_oe_n <= 1'b1;
        end else if (serial_override[OVR_FORCE]) begin
            link.sdo      <= serial_override[OVR_VALUE];
            link.sdo_oe_n <= 1'b0;
        end else if (reading) begin
            link.sdo      <= sdo_bit;
            link.sdo_oe_n <= 1'b0;
        end else begin
            link.sdo      <= lock_seen & enable_ctrl[EN_LOCK_GATE];
            link.sdo_oe_n <= ~enable_ctrl[EN_LOCK_GATE];
        end
    end

endmodule

// *** design/pll_serial_host.sv ***
// host end: register port to serial frames on the programming link
module pll_serial_host
    import pll_serial_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [3:0]  address,
    input  wire logic [23:0] write_data,
    input  wire logic        write_strobe,
    input  wire logic        read_strobe,
    output logic      [23:0] read_data,
    pll_link_if.host         link
);

    // ****************************************
    // state
    // ****************************************
    host_state_t state;
    logic [4:0]  half_count;
    logic        tick;
    logic [30:0] tx_frame;
    logic [5:0]  rises;
    logic        cmd_read;
    logic [5:0]  cmd_addr;
    logic [23:0] tx_data;
    logic [23:0] rx_data;
    logic        done;
    logic        start;
    logic [2:0]  sdo_sync;
    logic        sdo_level;

    assign start = write_strobe && address == HOST_COMMAND && state == HOST_IDLE;
    assign tick  = half_count == HALF_CYCLES - 5'h01;

    // sdo line: three stages, level moves when two and three agree
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sdo_sync  <= 3'h7;
            sdo_level <= 1'b1;
        end else begin
            sdo_sync <= {sdo_sync[1:0], link.sdo_line};
            if (sdo_sync[1] == sdo_sync[2]) begin
                sdo_level <= sdo_sync[2];
            end
        end
    end

    // half period divider, runs only during a frame and the gap after it
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            half_count <= 5'h00;
        end else if (state == HOST_IDLE || tick) begin
            half_count <= 5'h00;
        end else begin
            half_count <= half_count + 5'h01;
        end
    end

    // ****************************************
    // register port
    // ****************************************

    // command, write data and done flag; done set wins over clear
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cmd_read <= 1'b0;
            cmd_addr <= 6'h00;
            tx_data  <= 24'h000000;
            done     <= 1'b0;
        end else begin
            if (start) begin
                cmd_read <= write_data[CMD_READ];
                cmd_addr <= write_data[5:0];
            end
            if (write_strobe && address == HOST_WDATA && state == HOST_IDLE) begin
                tx_data <= write_data;
            end
            if (state == HOST_GAP && tick) begin
                done <= 1'b1;
            end else if (read_strobe && address == HOST_STATUS) begin
                done <= 1'b0;
            end
        end
    end

    // read data stands in the cycle after the strobe only
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            read_data <= 24'h000000;
        end else if (read_strobe) begin
            case (address)
                HOST_COMMAND: read_data <= {17'h00000, cmd_read, cmd_addr};
                HOST_WDATA:   read_data <= tx_data;
                HOST_RDATA:   read_data <= rx_data;
                HOST_STATUS:  read_data <= {22'h000000, done, state != HOST_IDLE};
                default:      read_data <= 24'h000000;
            endcase
        end else begin
            read_data <= 24'h000000;
        end
    end

    // ****************************************
    // frame engine
    // ****************************************

    // bits change on falls, device samples on rises
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state     <= HOST_IDLE;
            link.sen  <= 1'b0;
            link.sclk <= 1'b0;
            link.sdi  <= 1'b0;
            tx_frame  <= 31'h00000000;
            rises     <= 6'h00;
            rx_data   <= 24'h000000;
        end else begin
            case (state)
                HOST_IDLE: begin
                    if (start) begin
                        state    <= HOST_SHIFT;
                        link.sen <= 1'b1;
                        link.sdi <= write_data[CMD_READ];
                        tx_frame <= {write_data[CMD_READ], write_data[5:0],
                                     write_data[CMD_READ] ? 24'h000000 : tx_data};
                        rises    <= 6'h00;
                    end
                end
                HOST_SHIFT: begin
                    if (tick && !link.sclk) begin
                        link.sclk <= 1'b1;
                        rises     <= rises + 6'h01;
                    end else if (tick) begin
                        link.sclk <= 1'b0;
                        if (cmd_read && rises > FIRST_DATA_RISE && rises < FINAL_RISE) begin
                            rx_data <= {rx_data[22:0], sdo_level};
                        end
                        if (rises == FINAL_RISE) begin
                            state    <= HOST_GAP;
                            link.sen <= 1'b0;
                            link.sdi <= 1'b0;
                        end else begin
                            tx_frame <= {tx_frame[29:0], 1'b0};
                            link.sdi <= tx_frame[29];
                        end
                    end
                end
                HOST_GAP: begin
                    if (tick) begin
                        state <= HOST_IDLE;
                    end
                end
                default: state <= HOST_IDLE;
            endcase
        end
    end

endmodule

// *** sim/pll_enable_strobe_regs_chk.sv ***
// assertions on the programming link and the gated block controls
module pll_enable_strobe_regs_chk (
    input wire logic clock,
    input wire logic reset,
    input wire logic sen,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe_n,
    input wire logic bias_on,
    input wire logic pump_output_on,
    input wire logic ref_divider_run,
    input wire logic ref_divider_bypass,
    input wire logic soft_reset_digital,
    input wire logic temp_measure_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // framing, pin and control relations
    // ****************************************
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    // low half period after select, then the first rise
    sequence s_lead_in;
        !sclk[*8] ##[1:16] $rose(sclk);
    endsequence
    property p_first_rise; $rose(sen) |-> s_lead_in; endproperty
    property p_idle_low; !sen |-> !sclk; endproperty
    property p_half; $rose(sclk) |-> sclk[*8]; endproperty
    property p_sdi_hold; sen && sclk && $past(sclk) |-> $stable(sdi); endproperty
    property p_force_pin; $fell(reset) |-> ##[0:3] (!sdo_oe_n && sdo); endproperty
    property p_dig_pulse; $rose(soft_reset_digital) |=> !soft_reset_digital; endproperty
    property p_temp_pulse; $rose(temp_measure_strobe) |=> !temp_measure_strobe; endproperty
    property p_bias_gate; !bias_on |-> !pump_output_on; endproperty
    property p_div_hold; ref_divider_bypass |-> !ref_divider_run; endproperty

    a_first_rise:
        assert property (p_first_rise) else $error("late first rise");
    a_idle_low:
        assert property (p_idle_low) else $error("clock outside frame");
    a_half:
        assert property (p_half) else $error("short half period");
    a_sdi_hold:
        assert property (p_sdi_hold) else $error("data moved while high");
    a_force_pin:
        assert property (p_force_pin) else $error("pin not forced high");
    a_dig_pulse:
        assert property (p_dig_pulse) else $error("long digital reset");
    a_temp_pulse:
        assert property (p_temp_pulse) else $error("long temp strobe");
    a_bias_gate:
        assert property (p_bias_gate) else $error("pump on without bias");
    a_div_hold:
        assert property (p_div_hold) else $error("divider runs bypassed");
endmodule

// *** sim/pll_enable_strobe_regs_bench.sv ***
// self-checking bench for the synthesizer end and its host end
module pll_enable_strobe_regs_bench
    import pll_serial_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, reset = 1, write_strobe = 0, read_strobe = 0;
    logic [3:0] address = 4'h0;
    logic [23:0] write_data = 24'h000000, read_data, q;
    logic lock_detect_raw = 0, ref_sine_select = 0, slip_feature_on = 0, integer_mode = 0;
    logic vco_buffer_on, bias_on, ref_divider_run, ref_divider_bypass, refmux_clock_gate;
    logic divref_to_digital, square_clock_to_digital, sine_clock_to_digital;
    logic square_ref_buffer_on, sine_ref_buffer_on, modulator_clock_from_vco, prescaler_on;
    logic lock_detect_run, pump_output_on, modulator_run, lock_circuit_run, cycle_slip_guard;
    logic soft_reset_digital, temp_measure_strobe;
    int bad_count = 0, checks_done = 0, n_dig = 0, n_temp = 0;
    logic [15:0] pat [4] = '{16'hFFFD, 16'h7FFF, 16'hFFFF, 16'hA5A6};

    pll_link_if i_pll_link_if ();
    pll_enable_strobe_regs i_pll_enable_strobe_regs (.link(i_pll_link_if), .*);
    pll_serial_host i_pll_serial_host (.link(i_pll_link_if), .*);
    pll_enable_strobe_regs_chk i_pll_enable_strobe_regs_chk (.sen(i_pll_link_if.sen),
        .sclk(i_pll_link_if.sclk), .sdi(i_pll_link_if.sdi), .sdo(i_pll_link_if.sdo),
        .sdo_oe_n(i_pll_link_if.sdo_oe_n), .*);

    // ****************************************
    // clock, pulse counters and helpers
    // ****************************************
    always #2.5 clock = ~clock;
    always @(posedge clock) begin
        n_dig += int'(soft_reset_digital);
        n_temp += int'(temp_measure_strobe);
    end
    // block controls expected from enable bits and side inputs
    function automatic logic [23:0] outs(logic [15:0] e);
        logic b, s;
        b = e[1];
        s = ref_sine_select;
        return {7'h00, b & e[0], b, b & e[2], ~e[2], b & e[3], b & e[4], b & e[5], b & e[6],
            b & e[7] & ~s, b & e[8] & s, e[9], b & e[10], b & e[11], b & e[12],
            b & e[13] & ~integer_mode, b & e[14], b & e[15] & slip_feature_on};
    endfunction
    task chk(input string n, input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task chk_outs(input logic [15:0] e);
        chk("controls", {7'h00, vco_buffer_on, bias_on, ref_divider_run, ref_divider_bypass,
            refmux_clock_gate, divref_to_digital, square_clock_to_digital,
            sine_clock_to_digital, square_ref_buffer_on, sine_ref_buffer_on,
            modulator_clock_from_vco, prescaler_on, lock_detect_run, pump_output_on,
            modulator_run, lock_circuit_run, cycle_slip_guard}, outs(e));
    endtask
    task wr(input logic [3:0] a, input logic [23:0] d);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_strobe <= 1;
        @(posedge clock);
        write_strobe <= 0;
    endtask
    task rd(input logic [3:0] a, output logic [23:0] d);
        @(posedge clock);
        address <= a;
        read_strobe <= 1;
        @(posedge clock);
        read_strobe <= 0;
        #1 d = read_data;
    endtask
    // poll busy, bounded, then let effects land
    task idle;
        logic [23:0] s;
        repeat (1500) begin
            rd(HOST_STATUS, s);
            if (s[STAT_BUSY] === 1'b0) break;
        end
        chk("status", {22'h000000, s[STAT_DONE], s[STAT_BUSY]}, 24'h000002);
        repeat (8) @(posedge clock);
    endtask
    task dwr(input logic [5:0] a, input logic [23:0] d);
        wr(HOST_WDATA, d);
        wr(HOST_COMMAND, {18'h0, a});
        idle;
    endtask
    task drd(input logic [5:0] a, output logic [23:0] d);
        wr(HOST_COMMAND, {17'h0, 1'b1, a});
        idle;
        rd(HOST_RDATA, d);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task t_defaults;
        chk_outs(ENABLE_RESET);
        drd(ADDR_ENABLE, q);
        chk("forced read", q, 24'hFFFFFF);
        dwr(ADDR_OVERRIDE, 24'h000002);
        drd(ADDR_ENABLE, q);
        chk("forced low", q, 24'h000000);
        dwr(ADDR_OVERRIDE, 24'h000000);
        drd(ADDR_ENABLE, q);
        chk("enable read", q, {8'h00, ENABLE_RESET});
    endtask
    task t_lock;
        chk("lock pin low", {23'h0, i_pll_link_if.sdo_line}, 24'h000000);
        @(posedge clock) lock_detect_raw <= 1;
        repeat (8) @(posedge clock);
        chk("lock pin", {23'h0, i_pll_link_if.sdo_line}, 24'h000001);
    endtask
    task t_enable;
        for (int i = 0; i < 4; i++) begin
            @(posedge clock) {ref_sine_select, slip_feature_on, integer_mode} <= 3'(i * 3);
            dwr(ADDR_ENABLE, {8'h00, pat[i]});
            chk_outs(pat[i]);
            rd(HOST_WDATA, q);
            chk("wdata back", q, {8'h00, pat[i]});
            drd(ADDR_ENABLE, q);
            chk("enable back", q, {8'h00, pat[i]});
        end
    endtask
    task t_strobes;
        n_dig = 0;
        n_temp = 0;
        dwr(ADDR_STROBE, 24'h00000E);
        chk("digital pulses", 24'(n_dig), 24'h000001);
        chk("temp pulses", 24'(n_temp), 24'h000001);
        dwr(ADDR_ENABLE, 24'h000000);
        dwr(ADDR_STROBE, 24'h000001);
        chk_outs(ENABLE_RESET);
        drd(ADDR_ENABLE, q);
        chk("restored force", q, 24'hFFFFFF);
    endtask

    task print_verdict;
        $display("mismatches %0d comparisons %0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge clock);
        reset <= 0;
        repeat (4) @(posedge clock);
        t_defaults;
        t_lock;
        t_enable;
        t_strobes;
        print_verdict;
    end
    // watchdog
    initial begin
        repeat (60000) @(posedge clock);
        bad_count++;
        print_verdict;
    end
endmodule
